// ---- hw/egp_gpio.sv ----
// eight-pin general-purpose port with dual register views and secondary pin takeover
`timescale 1ns/100ps
module egp_gpio
    import egp_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        LINK_RST_N_I,
    input  wire logic        GLOBAL_RST_N_I,
    input  wire logic        REG_REQ_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_CFG_I,
    input  wire logic [7:0]  REG_ADDR_I,
    input  wire logic [15:0] REG_WDATA_I,
    input  wire logic [1:0]  REG_BE_I,
    output logic             REG_ACK_O,
    output logic [15:0]      REG_RDATA_O,
    input  wire logic        CLOCK_RUN_REQUEST_EN_I,
    input  wire logic        POWER_OVERRIDE_EN_I,
    input  wire logic        SERIAL_EN_I,
    input  wire logic [7:0]  SEC_DRV_I,
    input  wire logic [7:0]  SEC_OE_N_I,
    input  wire logic [7:0]  PIN_I,
    output logic [7:0]       PIN_O,
    output logic [7:0]       PIN_OE_N_O,
    output logic [7:0]       PIN_LEVEL_O
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // pins currently owned by a secondary function
    function automatic logic [7:0] sec_mask(input logic clock_run_request, input logic pwr, input logic ser);
        logic [7:0] m;
        m = 8'h00;
        m[EGP_PIN_CLOCK_RUN_REQUEST] = clock_run_request;
        m[EGP_PIN_PWROVR] = pwr;
        m[EGP_PIN_SCL]    = ser;
        m[EGP_PIN_SDA]    = ser;
        return m;
    endfunction : sec_mask

    // both access paths land on the same storage
    function automatic egp_hit_t decode(input logic cfg, input logic [7:0] addr);
        egp_hit_t h;
        h.dir = cfg ? (addr == EGP_CFG_DIR_OFS) : (addr == EGP_MEM_DIR_OFS);
        h.dat = cfg ? (addr == EGP_CFG_DAT_OFS) : (addr == EGP_MEM_DAT_OFS);
        return h;
    endfunction : decode

    egp_state_t st;
    egp_state_t nxt_st;
    logic [7:0] sec;
    egp_hit_t   hit;
    logic [7:0] out_mask;
    logic [7:0] level;
    logic       wr_lo;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    // one cycle of latency on every access keeps the read mux off the bus path
    always_comb begin
        nxt_st    = st;
        sec       = sec_mask(CLOCK_RUN_REQUEST_EN_I, POWER_OVERRIDE_EN_I, SERIAL_EN_I);
        hit       = decode(REG_CFG_I, REG_ADDR_I);
        out_mask  = st.dir & ~sec;
        wr_lo     = REG_REQ_I & REG_WR_I & REG_BE_I[0];
        // input or secondary pins show the pin, output pins the stored value
        level     = (out_mask & st.data) | (~out_mask & st.pin_s2);

        // two-stage pin and reset synchronisers
        nxt_st.pin_s1    = PIN_I;
        nxt_st.pin_s2    = st.pin_s1;
        nxt_st.lrst_n_s1 = LINK_RST_N_I;
        nxt_st.lrst_n_s2 = st.lrst_n_s1;
        nxt_st.global_reset_input_n_s1 = GLOBAL_RST_N_I;
        nxt_st.global_reset_input_n_s2 = st.global_reset_input_n_s1;

        // register writes; upper byte lane is reserved and dropped
        if (wr_lo && hit.dir) begin
            nxt_st.dir = REG_WDATA_I[7:0];
        end
        if (wr_lo && hit.dat) begin
            nxt_st.data = (st.data & ~out_mask) | (REG_WDATA_I[7:0] & out_mask);
        end

        // link or global reset wins over a write in the same cycle
        if (!st.lrst_n_s2 || !st.global_reset_input_n_s2) begin
            nxt_st.dir  = EGP_DIR_RST;
            nxt_st.data = EGP_DAT_RST;
        end

        // read answer; writes and unmapped reads return zero
        nxt_st.ack   = REG_REQ_I;
        nxt_st.rdata = EGP_UNMAP_RD;
        if (REG_REQ_I && !REG_WR_I) begin
            if (hit.dir) begin
                nxt_st.rdata = {EGP_RSVD_RD, st.dir};
            end else if (hit.dat) begin
                nxt_st.rdata = {EGP_RSVD_RD, level};
            end
        end

        // pin drive: secondary function owns its pins outright
        nxt_st.pin_oe_n = (sec & SEC_OE_N_I) | (~sec & ~st.dir);
        nxt_st.pin_out  = (sec & SEC_DRV_I) | (~sec & st.data);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // power-on reset clears everything except the output enables, which reset high so pins float as inputs
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st.dir       <= EGP_DIR_RST;
            st.data      <= EGP_DAT_RST;
            st.pin_s1    <= EGP_PINS_RST;
            st.pin_s2    <= EGP_PINS_RST;
            st.lrst_n_s1 <= 1'b0;
            st.lrst_n_s2 <= 1'b0;
            st.global_reset_input_n_s1 <= 1'b0;
            st.global_reset_input_n_s2 <= 1'b0;
            st.pin_out   <= EGP_PINS_RST;
            st.pin_oe_n  <= EGP_OE_N_RST;
            st.ack       <= 1'b0;
            st.rdata     <= EGP_UNMAP_RD;
        end else begin
            st <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    assign REG_ACK_O   = st.ack;
    assign REG_RDATA_O = st.rdata;
    assign PIN_O       = st.pin_out;
    assign PIN_OE_N_O  = st.pin_oe_n;
    assign PIN_LEVEL_O = st.pin_s2;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    logic [1:0] past_ok;
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            past_ok <= 2'b00;
        end else begin
            past_ok <= {past_ok[0], 1'b1};
        end
    end

    // plain pins drive exactly when their direction bit is set
    plain_pin_dir_a: assert property (past_ok[0] |->
        ((PIN_OE_N_O ^ ~$past(st.dir)) & ~$past(sec)) == 8'h00)
        else $error("plain pin enable does not follow direction");

    // secondary pins follow the secondary enable, never the direction bit
    sec_pin_own_a: assert property (past_ok[0] |->
        ((PIN_OE_N_O ^ $past(SEC_OE_N_I)) & $past(sec)) == 8'h00)
        else $error("secondary pin enable not owned by secondary function");

    // serial enable takes both pins 4 and 5, nothing else
    serial_pin_map_a: assert property (SERIAL_EN_I && !CLOCK_RUN_REQUEST_EN_I && !POWER_OVERRIDE_EN_I |->
        sec == 8'h30)
        else $error("serial function takes wrong pins");

    // input-mode bits of a data read show the synchronised pin level
    read_input_a: assert property (REG_REQ_I && !REG_WR_I && hit.dat |=>
        ((REG_RDATA_O[7:0] ^ $past(st.pin_s2)) & ~$past(st.dir)) == 8'h00)
        else $error("input pin level not returned on read");

    // written output bit reaches the pin two cycles later
    write_output_a: assert property (wr_lo && hit.dat && out_mask[2] && st.lrst_n_s2 && st.global_reset_input_n_s2
        && !sec[2] |-> ##2 PIN_O[2] == $past(REG_WDATA_I[2], 2))
        else $error("output pin did not take written value");

    // masked bits keep their stored value through a data write; a sync reset clears legally
    write_discard_a: assert property (wr_lo && hit.dat && st.lrst_n_s2 && st.global_reset_input_n_s2 |=>
        ((st.data ^ $past(st.data)) & ~$past(out_mask)) == 8'h00)
        else $error("write to input or secondary pin was not dropped");

    // upper byte always reads zero
    reserved_zero_a: assert property (REG_ACK_O |-> REG_RDATA_O[15:8] == 8'h00)
        else $error("reserved bits read nonzero");

    // synchronised link or global reset clears both registers
    sync_reset_clr_a: assert property (!st.lrst_n_s2 || !st.global_reset_input_n_s2 |=>
        st.dir == 8'h00 && st.data == 8'h00)
        else $error("reset did not clear direction and data");

    // configuration-space write to the direction register lands in shared storage
    cfg_dir_alias_a: assert property (wr_lo && REG_CFG_I && REG_ADDR_I == EGP_CFG_DIR_OFS
        && st.lrst_n_s2 && st.global_reset_input_n_s2 |=> st.dir == $past(REG_WDATA_I[7:0]))
        else $error("direction alias write lost");

    // data read through either view returns the stored bits of plain output pins
    cfg_dat_alias_a: assert property (REG_REQ_I && !REG_WR_I && hit.dat |=>
        ((REG_RDATA_O[7:0] ^ $past(st.data)) & $past(st.dir) & ~$past(sec)) == 8'h00)
        else $error("output pin read does not return stored data");

    // pin level reaches the register view after two flops
    pin_sync_a: assert property (past_ok[1] |-> PIN_LEVEL_O == $past(PIN_I, 2))
        else $error("pin synchroniser depth wrong");

    cov_dir_write_c: cover property (wr_lo && hit.dir && REG_CFG_I);
    cov_out_drive_c: cover property (wr_lo && hit.dat && out_mask != 8'h00);
    cov_sec_take_c:  cover property (SERIAL_EN_I && st.dir[4]);
    cov_link_rst_c:  cover property (!st.lrst_n_s2 && st.dir != 8'h00);

endmodule : egp_gpio

// ---- hw/egp_pkg.sv ----
// package for the eight-pin general-purpose port: offsets, reset values and carriers
// How it works
// - one direction bit per pin in bits 7:0; 0 input, 1 output, reset input.
// - a pin held by its secondary function ignores its direction bit.
// - pin 0 clock-run, pin 1 power override, pins 4/5 serial clock and data.
// - reading the data register returns the live level of every input-mode pin.
// - writing a data bit of an output-mode pin changes the level driven.
// - data writes to input-mode or secondary-function pins are dropped.
// - bits 15:8 of both registers are read-only and read zero.
// - link reset, global reset and power-on reset clear direction and data bits.
// - after power-up the data low byte shows the sampled pin levels.
// - direction register at memory offset 40h and configuration offset B4h, one storage.
// - data register also at configuration offset B6h, same storage and behaviour.
package egp_pkg;

    // ----------------------------------------------------------------
    // register offsets, one map per access path
    // ----------------------------------------------------------------
    localparam logic [7:0]  EGP_MEM_DIR_OFS = 8'h40;
    localparam logic [7:0]  EGP_MEM_DAT_OFS = 8'h42;
    localparam logic [7:0]  EGP_CFG_DIR_OFS = 8'hB4;
    localparam logic [7:0]  EGP_CFG_DAT_OFS = 8'hB6;

    // ----------------------------------------------------------------
    // reset values and fixed read fields
    // ----------------------------------------------------------------
    localparam logic [7:0]  EGP_DIR_RST     = 8'h00;
    localparam logic [7:0]  EGP_DAT_RST     = 8'h00;
    localparam logic [7:0]  EGP_RSVD_RD     = 8'h00;
    localparam logic [15:0] EGP_UNMAP_RD    = 16'h0000;
    localparam logic [7:0]  EGP_PINS_RST    = 8'h00;
    localparam logic [7:0]  EGP_OE_N_RST    = 8'hFF;

    // ----------------------------------------------------------------
    // pins shared with secondary functions
    // ----------------------------------------------------------------
    localparam int          EGP_PIN_CLOCK_RUN_REQUEST  = 0;
    localparam int          EGP_PIN_PWROVR  = 1;
    localparam int          EGP_PIN_SCL     = 4;
    localparam int          EGP_PIN_SDA     = 5;

    // one decoded register hit
    typedef struct packed {
        logic dir;
        logic dat;
    } egp_hit_t;

    // complete state of the port
    typedef struct packed {
        logic [7:0]  dir;
        logic [7:0]  data;
        logic [7:0]  pin_s1;
        logic [7:0]  pin_s2;
        logic        lrst_n_s1;
        logic        lrst_n_s2;
        logic        global_reset_input_n_s1;
        logic        global_reset_input_n_s2;
        logic [7:0]  pin_out;
        logic [7:0]  pin_oe_n;
        logic        ack;
        logic [15:0] rdata;
    } egp_state_t;

endpackage : egp_pkg

// ---- test/egp_board.sv ----
// board model for the eight port pins: port drive or board level per pin
`timescale 1ns/100ps
module egp_board (
    input  wire logic [7:0] pin_out_i,
    input  wire logic [7:0] pin_oe_n_i,
    input  wire logic [7:0] board_lvl_i,
    output logic      [7:0] pin_o
);
    // a driven pin shows the port value, an undriven one the board pull level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_o[i] = (pin_oe_n_i[i] == 1'b0) ? pin_out_i[i] : board_lvl_i[i];
        end
    end
endmodule : egp_board

// ---- test/egp_gpio_tb.sv ----
// self-checking bench for the eight-pin port with its board model
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module egp_gpio_tb;
    import egp_pkg::*;
    logic        clk, arst_n, lrst_n, global_reset_input_n, req, wr, cfg, ack;
    logic [2:0]  en;
    logic [1:0]  be;
    logic [7:0]  addr, sdrv, soe_n, pin_in, pout, poe_n, plvl, board, m;
    logic [15:0] wd, rd, exp_rd;
    logic [15:0] expq[$];
    int          err_count, total_checks;

    egp_gpio dut_u (.MCLK_I(clk), .ARST_N_I(arst_n), .LINK_RST_N_I(lrst_n), .GLOBAL_RST_N_I(global_reset_input_n),
        .REG_REQ_I(req), .REG_WR_I(wr), .REG_CFG_I(cfg), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
        .REG_BE_I(be), .REG_ACK_O(ack), .REG_RDATA_O(rd), .CLOCK_RUN_REQUEST_EN_I(en[0]), .POWER_OVERRIDE_EN_I(en[1]),
        .SERIAL_EN_I(en[2]), .SEC_DRV_I(sdrv), .SEC_OE_N_I(soe_n), .PIN_I(pin_in), .PIN_O(pout),
        .PIN_OE_N_O(poe_n), .PIN_LEVEL_O(plvl));
    egp_board board_u (.pin_out_i(pout), .pin_oe_n_i(poe_n), .board_lvl_i(board), .pin_o(pin_in));

    // ----------------------------------------------------------------
    // clock, tasks and read monitor
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // one register access; expected read noted before the request goes out
    task automatic acc(input logic w, c, input logic [7:0] a, input logic [15:0] d, e, input logic [1:0] b = 2'b01);
        expq.push_back(w ? 16'h0000 : e);
        #1 {req, wr, cfg, addr, wd, be} = {1'b1, w, c, a, d, b};
        @(posedge clk);
    endtask : acc

    // idle cycles; fresh board and secondary values only when asked
    task automatic idl(input int n, input logic [2:0] e, input logic nr);
        #1 req = 1'b0;
        en = e;
        if (nr) begin
            {board, sdrv, soe_n} = 24'($urandom());
        end
        repeat (n) @(posedge clk);
    endtask : idl

    // pin check at mid cycle so the edge updates have landed
    task automatic pchk(input logic [7:0] eo, eoe);
        @(negedge clk);
        `CHK(pout, eo)
        `CHK(poe_n, eoe)
        `CHK(plvl, (~eoe & eo) | (eoe & board))
        @(posedge clk);
    endtask : pchk

    task close_out;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // bounded wait until every noted read has been answered
    task automatic drain(input string nm);
        repeat (8) if (expq.size() != 0) @(posedge clk);
        if (expq.size() != 0) begin
            err_count++;
            close_out();
        end else begin
            $display("test %s done", nm);
            @(posedge clk);
        end
    endtask : drain

    // oldest note against each acknowledged answer
    always @(negedge clk) begin
        if (ack === 1'b1) begin
            exp_rd = (expq.size() != 0) ? expq.pop_front() : 16'hDEAD;
            `CHK(rd, exp_rd)
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {arst_n, req, wr, cfg, en, addr, wd} = '0;
        be = 2'b01;
        {lrst_n, global_reset_input_n} = 2'b11;
        sdrv = 8'h00;
        soe_n = 8'hFF;
        void'($urandom(76293));
        board = 8'($urandom());
        repeat (2) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge clk);
        acc(0, 0, EGP_MEM_DIR_OFS, 0, 16'h0000);
        acc(0, 1, EGP_CFG_DIR_OFS, 0, 16'h0000);
        acc(0, 1, EGP_CFG_DAT_OFS, 0, {8'h00, board});
        acc(0, 0, 8'h50, 0, 16'h0000); // unmapped offset reads zero
        idl(1, 3'b000, 1'b0);
        pchk(8'h00, 8'hFF);
        drain("reset");
        // reserved bits dropped, both views share storage, input bits refuse data
        acc(1, 1, EGP_CFG_DIR_OFS, 16'hFF0F, 0);
        acc(1, 1, EGP_CFG_DIR_OFS, 16'h00F0, 0, 2'b10); // low lane off, nothing stored
        acc(0, 0, EGP_MEM_DIR_OFS, 0, 16'h000F);
        acc(1, 0, EGP_MEM_DAT_OFS, 16'hFFAA, 0);
        acc(0, 1, EGP_CFG_DAT_OFS, 0, {8'h00, board[7:4], 4'hA});
        idl(4, 3'b000, 1'b0);
        pchk(8'h0A, 8'hF0);
        acc(1, 0, EGP_MEM_DIR_OFS, 16'h00FF, 0);
        idl(4, 3'b000, 1'b0);
        pchk(8'h0A, 8'h00);
        drain("direction and data");
        // each secondary function takes its pins; data writes there are lost
        for (int k = 0; k < 3; k++) begin
            m = (k == 0) ? 8'h01 : (k == 1) ? 8'h02 : 8'h30;
            idl(1, 3'(1 << k), 1'b1);
            acc(1, 0, EGP_MEM_DAT_OFS, 16'h00FF, 0);
            idl(4, 3'(1 << k), 1'b0);
            pchk((sdrv & m) | ~m, soe_n & m);
            idl(3, 3'b000, 1'b0);
            pchk((8'h0A & m) | ~m, 8'h00);
            acc(1, 0, EGP_MEM_DAT_OFS, 16'h000A, 0);
            // drop the request so the last write is not taken again
            idl(1, 3'b000, 1'b0);
        end
        drain("secondary");
        // link reset then global reset clear both registers
        for (int g = 0; g < 2; g++) begin
            #1 {lrst_n, global_reset_input_n} = {g[0], ~g[0]};
            repeat (4) @(posedge clk);
            #1 {lrst_n, global_reset_input_n} = 2'b11;
            repeat (3) @(posedge clk);
            acc(0, 0, EGP_MEM_DIR_OFS, 0, 16'h0000);
            idl(2, 3'b000, 1'b1);
            pchk(8'h00, 8'hFF);
            acc(1, 1, EGP_CFG_DIR_OFS, 16'h00FF, 0);
            acc(1, 1, EGP_CFG_DAT_OFS, 16'h00AA, 0);
            idl(1, 3'b000, 1'b0);
        end
        idl(1, 3'b000, 1'b0);
        drain("resets");
        close_out();
    end
endmodule : egp_gpio_tb
